// file: design/deca_dma_events.sv
// DMA event cause flags, enables and interrupt summary, AXI4-Lite slave.
// Assumes the DMA engine reports each finished command as one pulse.
// How it works
// - Cause flags are set only when a DMA command finishes.
// - Writing one clears that cause flag; writing zero keeps it.
// - Bit 12 sets when the stop command ends a transfer.
// - Bit 10 sets when an internal end of transfer is seen.
// - Bit 8 sets when the transfer counter reaches zero.
// - Short packet before count zero: internal end 1, done 0.
// - Short packet and count zero: both flags set.
// - Count zero without short packet: only done flag set.
// - Done flag sets only while the transfer counter is enabled.
// - Internal end sets only for OUT short completions.
// - Internal end sets whenever an OUT short packet is moved.
// - A flag raises the interrupt only with its enable bit set.
// - Enable bits sit at 12, 10 and 8 like the causes.
// - Enables reset to zero on hardware and USB bus reset.
// - Each source has its own enable bit.
// - Interrupt output is high while the global register is nonzero.
// - Counter disable bit set to one turns the counter off.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module deca_dma_events
   import deca_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // AXI4-Lite write address
   input  wire logic [DECA_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output var  logic                   s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output var  logic                   s_axi_wready,
   // AXI4-Lite write response
   output var  logic [1:0]             s_axi_bresp,
   output var  logic                   s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [DECA_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output var  logic                   s_axi_arready,
   // AXI4-Lite read data
   output var  logic [31:0]            s_axi_rdata,
   output var  logic [1:0]             s_axi_rresp,
   output var  logic                   s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // DMA engine side
   input  wire deca_evt_t              dma_evt,
   input  wire logic                   usb_bus_reset,
   output var  logic                   counter_disable,
   // Interrupts
   output var  logic                   dma_irq,
   output var  logic                   int_out
);

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic                   awready_q;
   logic                   wready_q;
   logic                   bvalid_q;
   logic [1:0]             bresp_q;
   logic                   arready_q;
   logic                   rvalid_q;
   logic [1:0]             rresp_q;
   logic [31:0]            rdata_q;
   logic [DECA_ADDR_W-1:0] aw_addr_q;
   logic [15:0]            wdata_q;
   logic [1:0]             wstrb_q;
   logic [15:0]            enable_q;
   logic [15:0]            enable_d;
   logic                   cntdis_q;
   logic                   cntdis_d;
   logic                   dma_irq_q;
   logic                   int_q;
   logic                   stop_q;
   logic                   intend_q;
   logic                   done_q;
   logic                   glob_q;

   // -----------------------------------------------------------------
   // Bus handshakes
   // -----------------------------------------------------------------
   logic aw_hs;
   logic w_hs;
   logic b_hs;
   logic ar_hs;
   logic r_hs;
   logic wr_go;

   // A write runs once both halves are held and no answer is pending
   assign aw_hs = s_axi_awvalid & awready_q;
   assign w_hs  = s_axi_wvalid & wready_q;
   assign b_hs  = bvalid_q & s_axi_bready;
   assign ar_hs = s_axi_arvalid & arready_q;
   assign r_hs  = rvalid_q & s_axi_rready;
   assign wr_go = ~awready_q & ~wready_q & ~bvalid_q;

   // -----------------------------------------------------------------
   // Write address decode
   // -----------------------------------------------------------------
   logic wr_cause;
   logic wr_enable;
   logic wr_config;
   logic wr_global;
   logic wr_hit;
   logic lane_lo;
   logic lane_hi;

   assign wr_cause  = wr_go & (aw_addr_q == DECA_OFF_CAUSE);
   assign wr_enable = wr_go & (aw_addr_q == DECA_OFF_ENABLE);
   assign wr_config = wr_go & (aw_addr_q == DECA_OFF_CONFIG);
   assign wr_global = wr_go & (aw_addr_q == DECA_OFF_GLOBAL);
   assign wr_hit    = wr_cause | wr_enable | wr_config | wr_global;
   assign lane_lo   = wstrb_q[0];
   assign lane_hi   = wstrb_q[1];

   // Bytes of the write that reach the register, per strobe
   logic [15:0] wr_lanes;
   assign wr_lanes = {{8{lane_hi}}, {8{lane_lo}}};

   // -----------------------------------------------------------------
   // Cause flag set and clear terms
   // -----------------------------------------------------------------
   logic set_stop;
   logic set_intend;
   logic set_done;
   logic [15:0] cause_clr;

   // Flags are refreshed only on a finished command
   assign set_stop   = dma_evt.done & dma_evt.stop;
   // Only an OUT short packet marks an internal end
   assign set_intend = dma_evt.done & dma_evt.short_pkt
                     & dma_evt.dir_out;
   // A disabled counter never reports done
   assign set_done   = dma_evt.done & dma_evt.cnt_zero
                     & ~cntdis_q;
   // Write one clears, write zero keeps; reserved bits ignored
   assign cause_clr  = wr_cause ? (wdata_q & wr_lanes & DECA_EVT_MASK)
                                : 16'h0000;

   // -----------------------------------------------------------------
   // Cause flags
   // -----------------------------------------------------------------
   // Command stop flag
   deca_flag_cell u_stop (
      .clk     (clk),
      .rst     (rst),
      .bus_rst (usb_bus_reset),
      .set     (set_stop),
      .clr     (cause_clr[DECA_STOP_BIT]),
      .q       (stop_q)
   );

   // Internal end flag; set independently of done, so both may show
   deca_flag_cell u_intend (
      .clk     (clk),
      .rst     (rst),
      .bus_rst (usb_bus_reset),
      .set     (set_intend),
      .clr     (cause_clr[DECA_INTEND_BIT]),
      .q       (intend_q)
   );

   // Transfer done flag
   deca_flag_cell u_done (
      .clk     (clk),
      .rst     (rst),
      .bus_rst (usb_bus_reset),
      .set     (set_done),
      .clr     (cause_clr[DECA_DONE_BIT]),
      .q       (done_q)
   );

   // Reserved positions are constant zero
   logic [15:0] cause_vec;
   assign cause_vec = (16'(stop_q)   << DECA_STOP_BIT)
                    | (16'(intend_q) << DECA_INTEND_BIT)
                    | (16'(done_q)   << DECA_DONE_BIT);

   // -----------------------------------------------------------------
   // Enables and summary
   // -----------------------------------------------------------------
   logic [15:0] masked;
   logic        masked_any;

   // Per-source gating, enable bits share the cause positions
   assign masked     = cause_vec & enable_q;
   assign masked_any = |masked;
   assign enable_d   = wr_enable
                     ? ((enable_q & ~wr_lanes)
                        | (wdata_q & wr_lanes & DECA_EVT_MASK))
                     : enable_q;
   assign cntdis_d   = (wr_config & lane_lo)
                     ? wdata_q[DECA_CNTDIS_BIT] : cntdis_q;

   // Summary bit of the global register, cleared by writing one
   deca_flag_cell u_glob (
      .clk     (clk),
      .rst     (rst),
      .bus_rst (usb_bus_reset),
      .set     (masked_any),
      .clr     (wr_global & lane_lo & wdata_q[DECA_GLOB_BIT]),
      .q       (glob_q)
   );

   // Enables clear on both resets, counter disable likewise
   always_ff @(posedge clk) begin
      if (rst || usb_bus_reset) begin
         enable_q <= DECA_ENABLE_RST;
         cntdis_q <= DECA_CNTDIS_RST;
      end else begin
         enable_q <= enable_d;
         cntdis_q <= cntdis_d;
      end
   end

   // Registered interrupt outputs; summary holds while an enabled cause stays set
   always_ff @(posedge clk) begin
      if (rst) begin
         dma_irq_q <= 1'b0;
         int_q     <= 1'b0;
      end else begin
         dma_irq_q <= masked_any;
         int_q     <= glob_q;
      end
   end

   // -----------------------------------------------------------------
   // Write channel
   // -----------------------------------------------------------------
   // Address and data are taken in either order and held until answer
   always_ff @(posedge clk) begin
      if (rst) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= DECA_RESP_OKAY;
      end else begin
         if (aw_hs) begin
            awready_q <= 1'b0;
         end else if (b_hs) begin
            awready_q <= 1'b1;
         end
         if (w_hs) begin
            wready_q <= 1'b0;
         end else if (b_hs) begin
            wready_q <= 1'b1;
         end
         if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? DECA_RESP_OKAY : DECA_RESP_SLVERR;
         end else if (b_hs) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Payload capture; only the low half carries register bits
   always_ff @(posedge clk) begin
      if (rst) begin
         aw_addr_q <= '0;
         wdata_q   <= 16'h0000;
         wstrb_q   <= 2'h0;
      end else begin
         if (aw_hs) begin
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_hs) begin
            wdata_q <= s_axi_wdata[15:0];
            wstrb_q <= s_axi_wstrb[1:0];
         end
      end
   end

   // -----------------------------------------------------------------
   // Read channel
   // -----------------------------------------------------------------
   logic        rd_hit;
   logic [31:0] rd_word;

   assign rd_hit  = (s_axi_araddr == DECA_OFF_CAUSE)
                  | (s_axi_araddr == DECA_OFF_ENABLE)
                  | (s_axi_araddr == DECA_OFF_CONFIG)
                  | (s_axi_araddr == DECA_OFF_GLOBAL);
   assign rd_word =
        (s_axi_araddr == DECA_OFF_CAUSE)  ? {16'h0000, cause_vec}
      : (s_axi_araddr == DECA_OFF_ENABLE) ? {16'h0000, enable_q}
      : (s_axi_araddr == DECA_OFF_CONFIG)
        ? (32'(cntdis_q) << DECA_CNTDIS_BIT)
      : (s_axi_araddr == DECA_OFF_GLOBAL)
        ? (32'(glob_q) << DECA_GLOB_BIT)
      : 32'h0000_0000;

   // Read answers one cycle after the address is taken
   always_ff @(posedge clk) begin
      if (rst) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rresp_q   <= DECA_RESP_OKAY;
         rdata_q   <= 32'h0000_0000;
      end else begin
         if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word;
            rresp_q   <= rd_hit ? DECA_RESP_OKAY : DECA_RESP_SLVERR;
         end else if (r_hs) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign s_axi_awready   = awready_q;
   assign s_axi_wready    = wready_q;
   assign s_axi_bvalid    = bvalid_q;
   assign s_axi_bresp     = bresp_q;
   assign s_axi_arready   = arready_q;
   assign s_axi_rvalid    = rvalid_q;
   assign s_axi_rresp     = rresp_q;
   assign s_axi_rdata     = rdata_q;
   assign counter_disable = cntdis_q;
   assign dma_irq         = dma_irq_q;
   assign int_out         = int_q;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   // Stop command raises its flag on the next edge
   property p_stop_set;
      @(posedge clk) disable iff (rst)
      (dma_evt.done && dma_evt.stop && !usb_bus_reset) |=> stop_q;
   endproperty
   a_stop_set: assert property (p_stop_set)
      else $error("stop flag not set after stop command");

   // Counter at zero with counter enabled raises done
   property p_done_set;
      @(posedge clk) disable iff (rst)
      (dma_evt.done && dma_evt.cnt_zero && !cntdis_q && !usb_bus_reset)
      |=> done_q;
   endproperty
   a_done_set: assert property (p_done_set)
      else $error("done flag not set at count zero");

   // Done never rises while the counter is disabled
   property p_done_gated;
      @(posedge clk) disable iff (rst)
      $rose(done_q) |-> $past(set_done) && !$past(cntdis_q);
   endproperty
   a_done_gated: assert property (p_done_gated)
      else $error("done flag rose with counter disabled");

   // Internal end rises only from an OUT short packet
   property p_intend_out;
      @(posedge clk) disable iff (rst)
      $rose(intend_q) |->
         $past(dma_evt.done && dma_evt.short_pkt && dma_evt.dir_out);
   endproperty
   a_intend_out: assert property (p_intend_out)
      else $error("internal end rose without OUT short packet");

   // Writing one clears a flag when no new event arrives
   property p_w1c;
      @(posedge clk) disable iff (rst)
      (wr_cause && lane_hi && wdata_q[DECA_STOP_BIT] && !set_stop)
      |=> !stop_q;
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("stop flag not cleared by write one");

   // Writing zero keeps a set flag
   property p_w0_keep;
      @(posedge clk) disable iff (rst)
      (wr_cause && !wdata_q[DECA_DONE_BIT] && done_q && !usb_bus_reset)
      |=> done_q;
   endproperty
   a_w0_keep: assert property (p_w0_keep)
      else $error("done flag lost on write zero");

   // Request follows enabled causes one edge later, both ways
   property p_irq_level;
      @(posedge clk) disable iff (rst)
      ##1 (dma_irq_q == $past(masked_any));
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("dma request does not track cause and enable");

   // No cause raises the request while every enable is clear
   property p_irq_masked;
      @(posedge clk) disable iff (rst)
      (enable_q == 16'h0000) |=> !dma_irq_q;
   endproperty
   a_irq_masked: assert property (p_irq_masked)
      else $error("dma request with all enables clear");

   // Bus reset empties enables and causes
   property p_bus_reset;
      @(posedge clk) disable iff (rst)
      usb_bus_reset |=> (enable_q == 16'h0000) && (cause_vec == 16'h0000);
   endproperty
   a_bus_reset: assert property (p_bus_reset)
      else $error("bus reset left enable or cause set");

   // Interrupt pin follows the global summary bit
   property p_int_pin;
      @(posedge clk) disable iff (rst)
      glob_q |=> int_q ##1 (int_q == $past(glob_q));
   endproperty
   a_int_pin: assert property (p_int_pin)
      else $error("interrupt pin does not follow summary bit");

endmodule : deca_dma_events
`default_nettype wire

// file: design/deca_pkg.sv
// Package for the DMA event cause and mask block.
// Assumes an AXI4-Lite master with 32-bit data and byte addresses.
package deca_pkg;

   // -----------------------------------------------------------------
   // Register offsets (byte addresses)
   // -----------------------------------------------------------------
   localparam int unsigned DECA_ADDR_W = 8;
   localparam logic [7:0] DECA_OFF_GLOBAL = 8'h18;
   localparam logic [7:0] DECA_OFF_CONFIG = 8'h38;
   localparam logic [7:0] DECA_OFF_CAUSE  = 8'h50;
   localparam logic [7:0] DECA_OFF_ENABLE = 8'h54;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int unsigned DECA_STOP_BIT   = 12;
   localparam int unsigned DECA_INTEND_BIT = 10;
   localparam int unsigned DECA_DONE_BIT   = 8;
   localparam int unsigned DECA_CNTDIS_BIT = 7;
   localparam int unsigned DECA_GLOB_BIT   = 6;

   // -----------------------------------------------------------------
   // Reset values and masks
   // -----------------------------------------------------------------
   localparam logic [15:0] DECA_CAUSE_RST  = 16'h0000;
   localparam logic [15:0] DECA_ENABLE_RST = 16'h0000;
   localparam logic [15:0] DECA_EVT_MASK   = 16'h1500;
   localparam logic        DECA_CNTDIS_RST = 1'b0;

   // -----------------------------------------------------------------
   // Bus answers
   // -----------------------------------------------------------------
   localparam logic [1:0] DECA_RESP_OKAY   = 2'h0;
   localparam logic [1:0] DECA_RESP_SLVERR = 2'h2;

   // Completion report from the DMA engine, valid with done
   typedef struct packed {
      logic done;       // One-cycle pulse: a DMA command finished
      logic stop;       // The command was the stop command
      logic short_pkt;  // A short packet was moved
      logic dir_out;    // Transfer direction is OUT
      logic cnt_zero;   // Transfer counter reached zero
   } deca_evt_t;

endpackage : deca_pkg

// file: design/deca_flag_cell.sv
// One sticky event flag with write-one-to-clear.
// Assumes set and clear are synchronous one-cycle terms.
`timescale 1ns/1ps
`default_nettype none
module deca_flag_cell
   import deca_pkg::*;
(
   // Clock and resets
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic bus_rst,
   // Control
   input  wire logic set,
   input  wire logic clr,
   // State
   output var  logic q
);

   // -----------------------------------------------------------------
   // Flag
   // -----------------------------------------------------------------
   logic q_d;

   // Set beats clear so an event in the clearing cycle survives
   assign q_d = set | (q & ~clr);

   // Either reset empties the flag
   always_ff @(posedge clk) begin
      if (rst || bus_rst) begin
         q <= 1'b0;
      end else begin
         q <= q_d;
      end
   end

endmodule : deca_flag_cell
`default_nettype wire

// file: dv/deca_dma_events_tb.sv
// Self-checking bench for the DMA event cause and mask block.
// Drives the AXI4-Lite port and the DMA event port directly.
`timescale 1ns/1ps
`default_nettype none
module deca_dma_events_tb
   import deca_pkg::*;
;
   logic                   clk = 1'b0;
   logic                   rst;
   logic [DECA_ADDR_W-1:0] awaddr, araddr;
   logic [31:0]            wdata, rdata;
   logic [3:0]             wstrb;
   logic [1:0]             bresp, rresp;
   logic                   awvalid, awready, wvalid, wready, bvalid, bready;
   logic                   arvalid, arready, rvalid, rready;
   deca_evt_t              dma_evt;
   logic                   usb_bus_reset, counter_disable, dma_irq, int_out;
   logic [15:0]            cause_e, en_e, rnd;
   logic                   cd_e;
   int                     failures, cmp_count;
   int                     cyc = 0;

   // 125 MHz clock
   always #4 clk = ~clk;

   deca_dma_events dut (
      .clk(clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dma_evt(dma_evt),
      .usb_bus_reset(usb_bus_reset), .counter_disable(counter_disable),
      .dma_irq(dma_irq), .int_out(int_out)
   );

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   // Flags one finished command should raise; b = stop,short,out,zero
   function automatic logic [15:0] exp_set(input logic [3:0] b,
                                           input logic cd);
      exp_set = 16'h0000;
      exp_set[DECA_STOP_BIT]   = b[3];
      exp_set[DECA_INTEND_BIT] = b[2] & b[1];
      exp_set[DECA_DONE_BIT]   = b[0] & ~cd;
   endfunction : exp_set

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what,
                  got, exp);
      end
   endtask : chk

   // Payload held until each channel's own ready; bready up from start
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                            input logic [1:0] er);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      chk({30'h0, bresp}, {30'h0, er}, "write response");
      bready <= 1'b0;
      @(posedge clk);
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, input logic [31:0] ed,
                           input logic [1:0] er);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      chk(rdata, ed, "read data");
      chk({30'h0, rresp}, {30'h0, er}, "read response");
      rready <= 1'b0;
      @(posedge clk);
   endtask : axi_read

   // One finished command; waits until the irq has settled
   // Counts are taken as whole packets, so a short packet is a true end
   task automatic fire(input logic [3:0] b);
      dma_evt <= '{done: 1'b1, stop: b[3], short_pkt: b[2], dir_out: b[1],
                   cnt_zero: b[0]};
      @(posedge clk);
      dma_evt <= '0;
      cause_e = cause_e | exp_set(b, cd_e);
      repeat (3) @(posedge clk);
   endtask : fire

   task automatic print_verdict;
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict

   // Hang guard: the whole run needs about a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         $display("wrong value at %0t: run timed out", $time);
         print_verdict();
      end
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      rst = 1'b1; awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hF;
      awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
      rready = 1'b0; dma_evt = '0; usb_bus_reset = 1'b0;
      failures = 0; cmp_count = 0; cause_e = '0; en_e = '0; cd_e = 1'b0;
      rnd = 16'h16DB;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      axi_read(DECA_OFF_CAUSE, 32'h0, DECA_RESP_OKAY);
      axi_read(DECA_OFF_ENABLE, 32'h0, DECA_RESP_OKAY);
      axi_read(DECA_OFF_CONFIG, 32'h0, DECA_RESP_OKAY);
      axi_write(DECA_OFF_ENABLE, {16'h0, DECA_EVT_MASK},
                DECA_RESP_OKAY);
      // Low lane alone cannot touch the enable bits in the high byte
      wstrb <= 4'h1;
      axi_write(DECA_OFF_ENABLE, 32'h0, DECA_RESP_OKAY);
      wstrb <= 4'hF;
      axi_read(DECA_OFF_ENABLE, {16'h0, DECA_EVT_MASK}, DECA_RESP_OKAY);
      axi_write(8'h5C, 32'h0000FFFF, DECA_RESP_SLVERR);
      axi_read(8'h5C, 32'h0, DECA_RESP_SLVERR);
      // Random mixes of completion kinds, enables and clears
      for (int i = 0; i < 32; i++) begin
         rnd = lfsr(rnd);
         en_e = rnd & DECA_EVT_MASK;
         cd_e = rnd[7];
         axi_write(DECA_OFF_ENABLE, {16'h0, en_e}, DECA_RESP_OKAY);
         axi_write(DECA_OFF_CONFIG, {24'h0, cd_e, 7'h00}, DECA_RESP_OKAY);
         chk({31'h0, counter_disable}, {31'h0, cd_e}, "cntdis");
         fire(rnd[3:0]);
         chk({31'h0, dma_irq}, {31'h0, |(cause_e & en_e)},
             "irq");
         axi_read(DECA_OFF_CAUSE, {16'h0, cause_e}, DECA_RESP_OKAY);
         rnd = lfsr(rnd);
         axi_write(DECA_OFF_CAUSE, {16'h0, rnd & DECA_EVT_MASK},
                   DECA_RESP_OKAY);
         cause_e = cause_e & ~(rnd & DECA_EVT_MASK);
         axi_write(DECA_OFF_GLOBAL, 32'h00000040, DECA_RESP_OKAY);
         repeat (4) @(posedge clk);
         chk({31'h0, dma_irq}, {31'h0, |(cause_e & en_e)}, "irq");
         chk({31'h0, int_out}, {31'h0, |(cause_e & en_e)}, "int");
         axi_read(DECA_OFF_CAUSE, {16'h0, cause_e}, DECA_RESP_OKAY);
      end
      // USB bus reset wipes flags, enables and the counter disable
      axi_write(DECA_OFF_ENABLE, {16'h0, DECA_EVT_MASK}, DECA_RESP_OKAY);
      axi_write(DECA_OFF_CONFIG, 32'h00000080, DECA_RESP_OKAY);
      cd_e = 1'b1;
      fire(4'b1111);
      usb_bus_reset <= 1'b1;
      @(posedge clk);
      usb_bus_reset <= 1'b0;
      repeat (3) @(posedge clk);
      axi_read(DECA_OFF_CAUSE, 32'h0, DECA_RESP_OKAY);
      axi_read(DECA_OFF_ENABLE, 32'h0, DECA_RESP_OKAY);
      axi_read(DECA_OFF_CONFIG, 32'h0, DECA_RESP_OKAY);
      chk({31'h0, dma_irq}, 32'h0, "irq after bus reset");
      chk({31'h0, int_out}, 32'h0, "int after bus reset");
      print_verdict();
   end
endmodule : deca_dma_events_tb
`default_nettype wire
